// ---- hrm_register_map.sv ----
// unified register page decoder: top of the host register map
// How it works
// [R1] every access is one aligned 16-bit word
// [R2] reserved reads return undefined, zero here
// [R3] host never writes reserved or undefined bits
// [R4] interrupt pin select at 0022h, pins 0-3
// [R5] dma channel select at 0024h, channels 0-2
// [R6] dma frame counter 0028h, 12 bits, read-only
// [R7] memory base 002Ch, four bytes, 20 bits
// [R8] boot rom mask 0034h, base 0030h
// [R9] current rx byte counter at 0050h
// [R10] config range 0100h, 32 bytes, read/write
// [R11] status range 0120h, 32 bytes, read-only
// [R12] multicast hash table 0150h, eight bytes
// [R13] rx status 0400h, length 0402h, data 0404h
// [R14] transmit command, length, window write-only
// [R15] page reached by memory and i/o; i/o default
`timescale 1ns/1ps
module hrm_register_map (
  input wire logic mclk,
  input wire logic reset,
  input wire hrm_pkg::hrm_req_s mem_req,
  input wire hrm_pkg::hrm_req_s io_req,
  input wire logic mem_mode_set,
  input wire hrm_pkg::hrm_dev_s dev_in,
  input wire logic [15:0] status_words [16],
  output logic [15:0] rdata,
  output logic rvalid,
  output logic [2:0] irq_select,
  output logic [1:0] dma_select,
  output logic [19:0] mem_base,
  output logic mem_mode,
  output logic tx_cmd_strobe,
  output logic [15:0] tx_cmd,
  output logic [15:0] tx_len,
  output logic tx_data_strobe,
  output logic [15:0] tx_data,
  output logic [11:0] tx_ptr,
  output logic rx_data_strobe,
  output logic [11:0] rx_ptr
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam int CFGW = hrm_pkg::CFG_WORDS * 16;
  typedef struct packed {
    logic [15:0] io_base;
    logic [2:0] irq_sel;
    logic [1:0] dma_sel;
    logic [31:0] mem_base;
    logic [31:0] rom_base;
    logic [31:0] rom_mask;
    logic [15:0] srom_cmd;
    logic [15:0] srom_data;
    logic [CFGW-1:0] cfg;
    logic [63:0] hash;
    logic [47:0] station;
    logic [15:0] tx_cmd;
    logic [15:0] tx_len;
    logic tx_cmd_stb;
    logic [15:0] tx_data;
    logic tx_data_stb;
    logic rx_data_stb;
    logic [15:0] rdata;
    logic rvalid;
    hrm_pkg::hrm_mode_e mode;
  } hrm_state_s;

  hrm_state_s st_reg;
  hrm_state_s st_next;
  hrm_pkg::hrm_req_s req;
  logic [11:0] rx_ptr_w;
  logic [11:0] tx_ptr_w;
  logic [11:0] waddr;
  logic rx_restart;
  logic tx_restart;

  // ---------------------------------------------------------------
  // word address helpers
  // ---------------------------------------------------------------
  // low address bit is dropped: only word access exists
  function automatic logic [11:0] word_of(input logic [11:0] a);
    word_of = {a[11:1], 1'b0}; // [R1]
  endfunction

  function automatic logic in_range(input logic [11:0] a,
                                    input logic [11:0] lo,
                                    input logic [11:0] bytes);
    in_range = (a >= lo) && (a < lo + bytes);
  endfunction

  // ---------------------------------------------------------------
  // access port selection and frame pointers
  // ---------------------------------------------------------------
  hrm_port_mux u_mux (
    .mem_enable(st_reg.mode == hrm_pkg::HRM_MODE_MEM), // [R15]
    .mem_req(mem_req),
    .io_req(io_req),
    .page_req(req)
  );

  assign waddr = word_of(req.addr);
  // reading receive status starts a fresh frame walk
  assign rx_restart = req.rd && (waddr == hrm_pkg::OFF_RX_STATUS);
  // a new transmit command restarts the transmit window walk
  assign tx_restart = req.wr && (waddr == hrm_pkg::OFF_TX_CMD);

  hrm_frame_ptr u_rx_ptr (
    .mclk(mclk),
    .reset(reset),
    .restart(rx_restart),
    .step(req.rd && in_range(waddr, hrm_pkg::OFF_RX_WINDOW,
                             12'h5FC)),
    .ptr(rx_ptr_w)
  );

  hrm_frame_ptr u_tx_ptr (
    .mclk(mclk),
    .reset(reset),
    .restart(tx_restart),
    .step(req.wr && (waddr >= hrm_pkg::OFF_TX_WINDOW)),
    .ptr(tx_ptr_w)
  );

  // ---------------------------------------------------------------
  // next-state logic: writes, reads, strobes
  // ---------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.tx_cmd_stb = 1'b0;
    st_next.tx_data_stb = 1'b0;
    st_next.rx_data_stb = 1'b0;
    st_next.rvalid = req.rd;
    st_next.rdata = hrm_pkg::UNDEF_READ; // [R2]
    if (mem_mode_set)
    begin
      st_next.mode = hrm_pkg::HRM_MODE_MEM; // [R15]
    end
    // writes; reserved targets fall through and are ignored
    if (req.wr) // [R3]
    begin
      if (waddr == hrm_pkg::OFF_IO_BASE)
      begin
        st_next.io_base = req.wdata;
      end
      else if (waddr == hrm_pkg::OFF_IRQ_SEL)
      begin
        st_next.irq_sel = req.wdata[2:0]; // [R4]
      end
      else if (waddr == hrm_pkg::OFF_DMA_SEL)
      begin
        st_next.dma_sel = req.wdata[1:0]; // [R5]
      end
      else if (waddr == hrm_pkg::OFF_MEM_BASE)
      begin
        st_next.mem_base[15:0] = req.wdata; // [R7]
      end
      else if (waddr == hrm_pkg::OFF_MEM_BASE + 12'h002)
      begin
        st_next.mem_base[31:16] = {12'h000, req.wdata[3:0]}; // [R7]
      end
      else if (waddr == hrm_pkg::OFF_ROM_BASE)
      begin
        st_next.rom_base[15:0] = req.wdata; // [R8]
      end
      else if (waddr == hrm_pkg::OFF_ROM_BASE + 12'h002)
      begin
        st_next.rom_base[31:16] = req.wdata; // [R8]
      end
      else if (waddr == hrm_pkg::OFF_ROM_MASK)
      begin
        st_next.rom_mask[15:0] = req.wdata; // [R8]
      end
      else if (waddr == hrm_pkg::OFF_ROM_MASK + 12'h002)
      begin
        st_next.rom_mask[31:16] = req.wdata; // [R8]
      end
      else if (waddr == hrm_pkg::OFF_SROM_CMD)
      begin
        st_next.srom_cmd = req.wdata;
      end
      else if (waddr == hrm_pkg::OFF_SROM_DATA)
      begin
        st_next.srom_data = req.wdata;
      end
      else if (in_range(waddr, hrm_pkg::OFF_CFG_RANGE, 12'h020))
      begin
        st_next.cfg[waddr[4:1]*16 +: 16] = req.wdata; // [R10]
      end
      else if (waddr == hrm_pkg::OFF_TX_CMD)
      begin
        st_next.tx_cmd = req.wdata; // [R14]
        st_next.tx_cmd_stb = 1'b1;
      end
      else if (waddr == hrm_pkg::OFF_TX_LEN)
      begin
        st_next.tx_len = req.wdata; // [R14]
      end
      else if (in_range(waddr, hrm_pkg::OFF_HASH, 12'h008))
      begin
        st_next.hash[waddr[2:1]*16 +: 16] = req.wdata; // [R12]
      end
      else if (in_range(waddr, hrm_pkg::OFF_STATION, 12'h006))
      begin
        st_next.station[(waddr[2:1] - 2'd0)*16 +: 16] = req.wdata;
      end
      else if (waddr >= hrm_pkg::OFF_TX_WINDOW)
      begin
        st_next.tx_data = req.wdata; // [R14]
        st_next.tx_data_stb = 1'b1;
      end
    end
    // reads; write-only and reserved words read as the undefined word
    if (req.rd)
    begin
      if (waddr == hrm_pkg::OFF_PRODUCT_ID_LO)
        st_next.rdata = hrm_pkg::PRODUCT_ID_VALUE[15:0];
      else if (waddr == hrm_pkg::OFF_PRODUCT_ID_HI)
        st_next.rdata = hrm_pkg::PRODUCT_ID_VALUE[31:16];
      else if (waddr == hrm_pkg::OFF_IO_BASE)
        st_next.rdata = st_reg.io_base;
      else if (waddr == hrm_pkg::OFF_IRQ_SEL)
        st_next.rdata = {13'h0, st_reg.irq_sel}; // [R4]
      else if (waddr == hrm_pkg::OFF_DMA_SEL)
        st_next.rdata = {14'h0, st_reg.dma_sel}; // [R5]
      else if (waddr == hrm_pkg::OFF_DMA_SOF)
        st_next.rdata = dev_in.dma_sof;
      else if (waddr == hrm_pkg::OFF_DMA_FRAMES)
        st_next.rdata = {4'h0, dev_in.dma_frames}; // [R6]
      else if (waddr == hrm_pkg::OFF_DMA_BYTES)
        st_next.rdata = dev_in.dma_bytes;
      else if (waddr == hrm_pkg::OFF_MEM_BASE)
        st_next.rdata = st_reg.mem_base[15:0]; // [R7]
      else if (waddr == hrm_pkg::OFF_MEM_BASE + 12'h002)
        st_next.rdata = st_reg.mem_base[31:16]; // [R7]
      else if (waddr == hrm_pkg::OFF_ROM_BASE)
        st_next.rdata = st_reg.rom_base[15:0]; // [R8]
      else if (waddr == hrm_pkg::OFF_ROM_BASE + 12'h002)
        st_next.rdata = st_reg.rom_base[31:16]; // [R8]
      else if (waddr == hrm_pkg::OFF_ROM_MASK)
        st_next.rdata = st_reg.rom_mask[15:0]; // [R8]
      else if (waddr == hrm_pkg::OFF_ROM_MASK + 12'h002)
        st_next.rdata = st_reg.rom_mask[31:16]; // [R8]
      else if (waddr == hrm_pkg::OFF_SROM_CMD)
        st_next.rdata = st_reg.srom_cmd;
      else if (waddr == hrm_pkg::OFF_SROM_DATA)
        st_next.rdata = st_reg.srom_data;
      else if (waddr == hrm_pkg::OFF_RX_BYTE_CNT)
        st_next.rdata = dev_in.rx_byte_cnt; // [R9]
      else if (in_range(waddr, hrm_pkg::OFF_CFG_RANGE, 12'h020))
        st_next.rdata = st_reg.cfg[waddr[4:1]*16 +: 16]; // [R10]
      else if (in_range(waddr, hrm_pkg::OFF_STAT_RANGE, 12'h020))
        st_next.rdata = status_words[waddr[4:1]]; // [R11]
      else if (in_range(waddr, hrm_pkg::OFF_HASH, 12'h008))
        st_next.rdata = st_reg.hash[waddr[2:1]*16 +: 16]; // [R12]
      else if (in_range(waddr, hrm_pkg::OFF_STATION, 12'h006))
        st_next.rdata = st_reg.station[waddr[2:1]*16 +: 16];
      else if (waddr == hrm_pkg::OFF_RX_STATUS)
        st_next.rdata = dev_in.rx_status; // [R13]
      else if (waddr == hrm_pkg::OFF_RX_LENGTH)
        st_next.rdata = dev_in.rx_length; // [R13]
      else if (in_range(waddr, hrm_pkg::OFF_RX_WINDOW, 12'h5FC))
      begin
        st_next.rdata = dev_in.rx_data; // [R13]
        st_next.rx_data_stb = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_reg <= '0;
      st_reg.io_base <= hrm_pkg::RST_IO_BASE;
      st_reg.irq_sel <= hrm_pkg::RST_IRQ_SEL;
      st_reg.dma_sel <= hrm_pkg::RST_DMA_SEL;
      st_reg.mode <= hrm_pkg::HRM_MODE_IO; // [R15]
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign rdata = st_reg.rdata;
  assign rvalid = st_reg.rvalid;
  assign irq_select = st_reg.irq_sel;
  assign dma_select = st_reg.dma_sel;
  assign mem_base = st_reg.mem_base[19:0];
  assign mem_mode = st_reg.mode;
  assign tx_cmd_strobe = st_reg.tx_cmd_stb;
  assign tx_cmd = st_reg.tx_cmd;
  assign tx_len = st_reg.tx_len;
  assign tx_data_strobe = st_reg.tx_data_stb;
  assign tx_data = st_reg.tx_data;
  assign tx_ptr = tx_ptr_w;
  assign rx_data_strobe = st_reg.rx_data_stb;
  assign rx_ptr = rx_ptr_w;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_irq_sel_write: assert property ( // [R4]
    @(posedge mclk) disable iff (reset)
    req.wr && waddr == hrm_pkg::OFF_IRQ_SEL |=>
    irq_select == $past(req.wdata[2:0]))
    else $error("interrupt select not stored");
  a_dma_sel_write: assert property ( // [R5]
    @(posedge mclk) disable iff (reset)
    req.wr && waddr == hrm_pkg::OFF_DMA_SEL |=>
    dma_select == $past(req.wdata[1:0]))
    else $error("dma select not stored");
  a_frame_cnt_top: assert property ( // [R6]
    @(posedge mclk) disable iff (reset)
    req.rd && waddr == hrm_pkg::OFF_DMA_FRAMES |=>
    rdata == {4'h0, $past(dev_in.dma_frames)})
    else $error("frame count readback wrong");
  // write then immediate read of the low word must return the host data
  a_mem_base_rt: assert property ( // [R7]
    @(posedge mclk) disable iff (reset)
    req.wr && waddr == hrm_pkg::OFF_MEM_BASE ##1
    !req.wr && req.rd && waddr == hrm_pkg::OFF_MEM_BASE |=>
    rdata == $past(req.wdata, 2))
    else $error("memory base readback wrong");
  a_rx_cnt_read: assert property ( // [R9]
    @(posedge mclk) disable iff (reset)
    req.rd && waddr == hrm_pkg::OFF_RX_BYTE_CNT |=>
    rvalid && rdata == $past(dev_in.rx_byte_cnt))
    else $error("rx byte counter readback wrong");
  a_stat_read: assert property ( // [R11]
    @(posedge mclk) disable iff (reset)
    req.rd && in_range(waddr, hrm_pkg::OFF_STAT_RANGE, 12'h020) |=>
    rdata == $past(status_words[waddr[4:1]]))
    else $error("status word readback wrong");
  a_tx_wo_read: assert property ( // [R14]
    @(posedge mclk) disable iff (reset)
    req.rd && (waddr == hrm_pkg::OFF_TX_CMD ||
    waddr == hrm_pkg::OFF_TX_LEN) |=> rdata == hrm_pkg::UNDEF_READ)
    else $error("write-only word read back data");
  a_tx_cmd_pulse: assert property ( // [R14]
    @(posedge mclk) disable iff (reset)
    req.wr && waddr == hrm_pkg::OFF_TX_CMD |=>
    tx_cmd_strobe && tx_cmd == $past(req.wdata))
    else $error("transmit command not strobed");
  a_rx_len_read: assert property ( // [R13]
    @(posedge mclk) disable iff (reset)
    req.rd && waddr == hrm_pkg::OFF_RX_LENGTH |=>
    rdata == $past(dev_in.rx_length))
    else $error("rx length readback wrong");
  a_io_default: assert property ( // [R15]
    @(posedge mclk)
    $fell(reset) |-> mem_mode == 1'b0)
    else $error("memory mode active after reset");

endmodule // hrm_register_map

// ---- hrm_pkg.sv ----
// package for the host register map decoder
package hrm_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses within the 4-Kbyte page)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_PRODUCT_ID_LO = 12'h000;
  localparam logic [11:0] OFF_PRODUCT_ID_HI = 12'h002;
  localparam logic [11:0] OFF_IO_BASE = 12'h020;
  localparam logic [11:0] OFF_IRQ_SEL = 12'h022;
  localparam logic [11:0] OFF_DMA_SEL = 12'h024;
  localparam logic [11:0] OFF_DMA_SOF = 12'h026;
  localparam logic [11:0] OFF_DMA_FRAMES = 12'h028;
  localparam logic [11:0] OFF_DMA_BYTES = 12'h02A;
  localparam logic [11:0] OFF_MEM_BASE = 12'h02C;
  localparam logic [11:0] OFF_ROM_BASE = 12'h030;
  localparam logic [11:0] OFF_ROM_MASK = 12'h034;
  localparam logic [11:0] OFF_SROM_CMD = 12'h040;
  localparam logic [11:0] OFF_SROM_DATA = 12'h042;
  localparam logic [11:0] OFF_RX_BYTE_CNT = 12'h050;
  localparam logic [11:0] OFF_CFG_RANGE = 12'h100;
  localparam logic [11:0] OFF_STAT_RANGE = 12'h120;
  localparam logic [11:0] OFF_TX_CMD = 12'h144;
  localparam logic [11:0] OFF_TX_LEN = 12'h146;
  localparam logic [11:0] OFF_HASH = 12'h150;
  localparam logic [11:0] OFF_STATION = 12'h158;
  localparam logic [11:0] OFF_RX_STATUS = 12'h400;
  localparam logic [11:0] OFF_RX_LENGTH = 12'h402;
  localparam logic [11:0] OFF_RX_WINDOW = 12'h404;
  localparam logic [11:0] OFF_TX_WINDOW = 12'hA00;
  localparam logic [11:0] OFF_TX_WINDOW_END = 12'hFFF;

  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int IRQ_SEL_W = 3;
  localparam int DMA_SEL_W = 2;
  localparam int FRAME_CNT_W = 12;
  localparam int MEM_BASE_W = 20;
  localparam int CFG_WORDS = 16;
  localparam int HASH_WORDS = 4;
  localparam int STATION_WORDS = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_IO_BASE = 16'h0300;
  localparam logic [2:0] RST_IRQ_SEL = 3'h4;
  localparam logic [1:0] RST_DMA_SEL = 2'h3;
  localparam logic [31:0] RST_ZERO32 = 32'h0000_0000;
  localparam logic [15:0] RST_ZERO16 = 16'h0000;
  // arbitrary neutral identification value
  localparam logic [31:0] PRODUCT_ID_VALUE = 32'h1234_5600;
  // undefined reads of reserved or write-only space return this
  localparam logic [15:0] UNDEF_READ = 16'h0000;

  // access modes of the page
  typedef enum logic [0:0] {
    HRM_MODE_IO = 1'b0,
    HRM_MODE_MEM = 1'b1
  } hrm_mode_e;

  // one host word access as presented to the page
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [15:0] wdata;
  } hrm_req_s;

  // words reported by the rest of the device
  typedef struct packed {
    logic [15:0] dma_sof;
    logic [11:0] dma_frames;
    logic [15:0] dma_bytes;
    logic [15:0] rx_byte_cnt;
    logic [15:0] rx_status;
    logic [15:0] rx_length;
    logic [15:0] rx_data;
  } hrm_dev_s;

endpackage

// ---- hrm_port_mux.sv ----
// merges the memory-space and i/o-space access ports into one request
`timescale 1ns/1ps
module hrm_port_mux (
  input wire logic mem_enable,
  input wire hrm_pkg::hrm_req_s mem_req,
  input wire hrm_pkg::hrm_req_s io_req,
  output hrm_pkg::hrm_req_s page_req
);
  // memory path only counts once software enables memory mode
  always_comb
  begin
    if (mem_enable && (mem_req.rd || mem_req.wr))
    begin
      page_req = mem_req;
    end
    else
    begin
      page_req = io_req;
    end
  end
endmodule // hrm_port_mux

// ---- hrm_frame_ptr.sv ----
// word pointer walking the receive or transmit frame window
`timescale 1ns/1ps
module hrm_frame_ptr (
  input wire logic mclk,
  input wire logic reset,
  input wire logic restart,
  input wire logic step,
  output logic [11:0] ptr
);
  typedef struct packed {
    logic [11:0] ptr;
  } hrm_ptr_s;
  hrm_ptr_s st_reg;
  hrm_ptr_s st_next;

  // one word per step; restart clears the walk
  always_comb
  begin
    st_next = st_reg;
    if (restart)
    begin
      st_next.ptr = 12'h000;
    end
    else if (step)
    begin
      st_next.ptr = st_reg.ptr + 12'h002;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign ptr = st_reg.ptr;
endmodule // hrm_frame_ptr

// ---- hrm_host_model.sv ----
// host-side bus model issuing word accesses to the register page
`timescale 1ns/1ps
module hrm_host_model (
  input wire logic mclk,
  input wire logic use_mem,
  output hrm_pkg::hrm_req_s mem_req,
  output hrm_pkg::hrm_req_s io_req
);
  hrm_pkg::hrm_req_s cur;
  hrm_pkg::hrm_req_s idl;

  // quiet ports at time zero
  initial
  begin
    cur = '0;
    mem_req = '0;
    io_req = '0;
  end

  // ---------------------------------------------------------------
  // access tasks, one request per cycle
  // ---------------------------------------------------------------
  // the unused port shows inverted lines, never a stale copy
  task automatic access(input logic rd, input logic wr,
                        input logic [11:0] a, input logic [15:0] d);
    @(posedge mclk);
    cur = '{rd: rd, wr: wr, addr: {a[11:1], 1'b0}, wdata: d};
    idl = '{rd: 1'b0, wr: 1'b0, addr: ~cur.addr, wdata: ~cur.wdata};
    mem_req <= use_mem ? cur : idl;
    io_req <= use_mem ? idl : cur;
  endtask

  // release both ports; callers only write defined places
  task automatic idle();
    @(posedge mclk);
    idl = '{rd: 1'b0, wr: 1'b0, addr: ~cur.addr, wdata: ~cur.wdata};
    mem_req <= idl;
    io_req <= idl;
  endtask
endmodule // hrm_host_model

// ---- tb_hrm_register_map.sv ----
// self-checking testbench for the host register map decoder
`timescale 1ns/1ps
module tb_hrm_register_map;
  logic mclk, reset, mem_mode_set, use_mem, rvalid, mem_mode;
  logic tx_cmd_strobe, tx_data_strobe, rx_data_strobe;
  hrm_pkg::hrm_req_s mem_req, io_req;
  hrm_pkg::hrm_dev_s dev_in;
  logic [15:0] status_words [16];
  logic [15:0] rdata, tx_cmd, tx_len, tx_data, w, v;
  logic [2:0] irq_select;
  logic [1:0] dma_select;
  logic [19:0] mem_base;
  logic [11:0] tx_ptr, rx_ptr;
  logic [15:0] exp_q [$];
  int fail_count, num_checks, txs, rxs, cms;
  logic [11:0] rw_a [12] = '{12'h020, 12'h030, 12'h032, 12'h034,
    12'h036, 12'h040, 12'h042, 12'h150, 12'h152, 12'h156, 12'h158,
    12'h15C};
  logic [11:0] rz_a [10] = '{12'h004, 12'h038, 12'h044, 12'h052,
    12'h140, 12'h148, 12'h15E, 12'h144, 12'h146, 12'hA00};

  hrm_register_map i_hrm_register_map (.mclk(mclk), .reset(reset),
    .mem_req(mem_req), .io_req(io_req), .mem_mode_set(mem_mode_set),
    .dev_in(dev_in), .status_words(status_words), .rdata(rdata),
    .rvalid(rvalid), .irq_select(irq_select), .dma_select(dma_select),
    .mem_base(mem_base), .mem_mode(mem_mode),
    .tx_cmd_strobe(tx_cmd_strobe), .tx_cmd(tx_cmd), .tx_len(tx_len),
    .tx_data_strobe(tx_data_strobe), .tx_data(tx_data),
    .tx_ptr(tx_ptr), .rx_data_strobe(rx_data_strobe), .rx_ptr(rx_ptr));

  hrm_host_model i_hrm_host_model (.mclk(mclk), .use_mem(use_mem),
    .mem_req(mem_req), .io_req(io_req));

  // ---------------------------------------------------------------
  // clock and result watcher
  // ---------------------------------------------------------------
  // 25 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // each read answer takes the oldest note, or 16'hDEAD when none is noted; strobes are counted
  always @(posedge mclk)
  begin
    if (tx_data_strobe === 1'b1) txs++;
    if (tx_cmd_strobe === 1'b1) cms++;
    if (rx_data_strobe === 1'b1) rxs++;
    if (rvalid === 1'b1)
    begin
      if (exp_q.size() == 0) chk_read(16'hDEAD, rdata);
      else chk_read(exp_q.pop_front(), rdata);
    end
  end

  // ---------------------------------------------------------------
  // compare, access and closing tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [19:0] e,
                     input logic [19:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic chk_read(input logic [15:0] e, input logic [15:0] g);
    chk("read data", {4'h0, e}, {4'h0, g});
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    i_hrm_host_model.access(1'b0, 1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    i_hrm_host_model.access(1'b1, 1'b0, a, 16'h0000);
  endtask

  // bounded wait until every noted read has been answered
  task automatic settle(input string nm);
    int n;
    i_hrm_host_model.idle();
    for (n = 0; n < 50 && exp_q.size() != 0; n++) @(posedge mclk);
    if (exp_q.size() != 0)
    begin
      fail_count++;
      stop_test();
    end
    // two edges so the watcher has counted the last strobe first
    repeat (2) @(posedge mclk);
    $display("test %s finished", nm);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    mem_mode_set = 1'b0;
    use_mem = 1'b0;
    dev_in = '0;
    foreach (status_words[k]) status_words[k] = 16'h0000;
    void'($urandom(32'h2916));
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    dev_in <= '{16'($urandom), 12'($urandom), 16'($urandom),
      16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom)};
    foreach (status_words[k]) status_words[k] <= 16'($urandom);
    // reset values and read-only words
    rd(12'h000, hrm_pkg::PRODUCT_ID_VALUE[15:0]);
    rd(12'h002, hrm_pkg::PRODUCT_ID_VALUE[31:16]);
    rd(12'h020, 16'h0300);
    rd(12'h022, 16'h0004);
    rd(12'h024, 16'h0003);
    rd(12'h02C, 16'h0000);
    wr(12'h026, 16'hFFFF);
    rd(12'h026, dev_in.dma_sof);
    rd(12'h028, {4'h0, dev_in.dma_frames});
    rd(12'h02A, dev_in.dma_bytes);
    wr(12'h050, 16'h5A5A);
    rd(12'h050, dev_in.rx_byte_cnt);
    for (int k = 0; k < 16; k++)
    begin
      wr(12'h120 + 12'(2 * k), 16'hA5A5);
      rd(12'h120 + 12'(2 * k), status_words[k]);
    end
    foreach (rz_a[k]) rd(rz_a[k], hrm_pkg::UNDEF_READ);
    settle("read only");
    chk("mem_mode", 20'h0, {19'h0, mem_mode});
    // read/write words, back to back
    foreach (rw_a[k])
    begin
      w = 16'($urandom);
      wr(rw_a[k], w);
      rd(rw_a[k], w);
    end
    for (int k = 0; k < 16; k++)
    begin
      w = 16'($urandom);
      wr(12'h100 + 12'(2 * k), w);
      rd(12'h100 + 12'(2 * k), w);
    end
    w = 16'($urandom);
    v = {12'h000, 4'($urandom)};
    wr(12'h02C, w);
    rd(12'h02C, w);
    wr(12'h02E, v);
    rd(12'h02E, v);
    settle("read write");
    chk("mem_base", {v[3:0], w}, mem_base);
    // every pin and channel selection
    for (int k = 0; k < 4; k++)
    begin
      wr(12'h022, 16'(k));
      if (k < 3) wr(12'h024, 16'(k));
      rd(12'h022, 16'(k));
      settle("selection");
      chk("irq_select", 20'(k), {17'h0, irq_select});
      chk("dma_select", 20'(k < 3 ? k : 2), {18'h0, dma_select});
    end
    // transmit command, length and frame words
    txs = 0;
    wr(12'h144, 16'hC0DE);
    wr(12'h146, 16'h0040);
    for (int k = 0; k < 3; k++) wr(12'hA00, 16'h1110 + 16'(k));
    settle("transmit");
    chk("tx_cmd", 20'h0C0DE, {4'h0, tx_cmd});
    chk("tx_len", 20'h00040, {4'h0, tx_len});
    chk("tx_data", 20'h01112, {4'h0, tx_data});
    chk("tx_ptr", 20'h6, {8'h0, tx_ptr});
    chk("tx strobes", 20'h3, 20'(txs));
    chk("cmd strobes", 20'h1, 20'(cms));
    // receive status, length and data words
    rxs = 0;
    rd(12'h400, dev_in.rx_status);
    rd(12'h402, dev_in.rx_length);
    for (int k = 0; k < 3; k++) rd(12'h404, dev_in.rx_data);
    settle("receive");
    chk("rx_ptr", 20'h6, {8'h0, rx_ptr});
    chk("rx strobes", 20'h3, 20'(rxs));
    // switch to memory space, then access through that port
    @(posedge mclk);
    mem_mode_set <= 1'b1;
    use_mem <= 1'b1;
    @(posedge mclk);
    mem_mode_set <= 1'b0;
    wr(12'h022, 16'h0001);
    rd(12'h022, 16'h0001);
    wr(12'h020, 16'h0360);
    rd(12'h020, 16'h0360);
    settle("memory space");
    chk("mem_mode", 20'h1, {19'h0, mem_mode});
    chk("irq_select", 20'h1, {17'h0, irq_select});
    stop_test();
  end
endmodule // tb_hrm_register_map
